// File: include/dpm_pkg.sv
// ----------------------------------------------------------------------------
// Shared constants of the pin and supply mode controller
// ----------------------------------------------------------------------------
package dpm_pkg;

    // Channel count and bus widths
    localparam int          NUM_CH    = 8;          // Output channels
    localparam int          ADDR_W    = 5;          // Byte address width
    localparam int          DATA_W    = 32;         // Bus data width

    // Register byte offsets
    localparam logic [4:0]  OFS_CHAN  = 5'h00;      // channel_on_bits
    localparam logic [4:0]  OFS_MAP_A = 5'h04;      // input_route_map_a
    localparam logic [4:0]  OFS_MAP_B = 5'h08;      // input_route_map_b
    localparam logic [4:0]  OFS_CTRL  = 5'h0C;      // Activation and PWM enables
    localparam logic [4:0]  OFS_PMAPA = 5'h10;      // PWM generator A routing
    localparam logic [4:0]  OFS_PMAPB = 5'h14;      // PWM generator B routing
    localparam logic [4:0]  OFS_STAT  = 5'h18;      // Level monitor and mode

    // Reset values
    localparam logic [7:0]  RST_CHAN  = 8'h00;      // All channels off
    localparam logic [7:0]  RST_MAP_A = 8'h04;      // Input a drives channel 2
    localparam logic [7:0]  RST_MAP_B = 8'h08;      // Input b drives channel 3
    localparam logic [2:0]  RST_CTRL  = 3'h0;       // Not activated, no PWM
    localparam logic [7:0]  RST_PMAP  = 8'h00;      // PWM routed nowhere

    // Control register field positions
    localparam int          CTRL_ACT  = 0;          // activation_bit
    localparam int          CTRL_PWMA = 1;          // pwm_enable_a
    localparam int          CTRL_PWMB = 2;          // pwm_enable_b

    // Status register field positions
    localparam int          STAT_LVLA = 0;          // Level of input a
    localparam int          STAT_LVLB = 1;          // Level of input b
    localparam int          STAT_MODE = 2;          // Mode, two bits
    localparam int          STAT_BUV  = 4;          // Battery undervoltage
    localparam int          STAT_LUV  = 5;          // Logic undervoltage

    // Operating modes
    typedef enum logic [1:0] {
        MODE_SLEEP,
        MODE_IDLE,
        MODE_ACTIVE,
        MODE_FAILSAFE
    } dpm_mode_t;

endpackage

// File: src/dpm_sync.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Two-stage synchroniser for asynchronous levels
// ----------------------------------------------------------------------------
module dpm_sync #(
    parameter int W = 1                             // Number of levels
) (
    input  wire logic         clk_in,               // Clock
    input  wire logic         arst_n_in,            // Async reset, active low
    input  wire logic [W-1:0] async_in,             // Levels from pins
    output logic      [W-1:0] sync_out              // Synchronised levels
);

    logic [W-1:0] meta_q;                           // First stage only
    logic [W-1:0] sync_q;                           // Second stage

    // Two flip-flops, first read only by second
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;

endmodule // dpm_sync

// File: src/dpm_top.sv
// Decided for this implementation: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
module dpm_top #(
    parameter int NCH = dpm_pkg::NUM_CH              // Channel count
) (
    input  wire logic                       ref_clk_in,          // 20 MHz clock
    input  wire logic                       arst_n_in,           // Async reset
    input  wire logic                       direct_input_a_in,   // Pin input a
    input  wire logic                       direct_input_b_in,   // Pin input b
    input  wire logic                       low_power_n_in,      // Low-power pin
    input  wire logic                       battery_uv_in,       // Battery below level
    input  wire logic                       logic_uv_in,         // Logic supply low
    input  wire logic                       pwm_gen_a_in,        // PWM generator a
    input  wire logic                       pwm_gen_b_in,        // PWM generator b
    input  wire logic [dpm_pkg::ADDR_W-1:0] avs_address,         // Byte address
    input  wire logic                       avs_read,            // Read request
    input  wire logic                       avs_write,           // Write request
    input  wire logic [dpm_pkg::DATA_W-1:0] avs_writedata,       // Write data
    output logic      [dpm_pkg::DATA_W-1:0] avs_readdata,        // Read data
    output logic                            avs_waitrequest,     // Stall
    output logic      [NCH-1:0]             channel_cmd_out,     // Channel on commands
    output logic      [1:0]                 mode_out,            // Operating mode
    output logic                            uv_monitor_en_out,   // Supply monitors on
    output logic                            serial_out_en_out    // Serial output enable
);

    // ------------------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------------------
    if (NCH < 4 || NCH > 8) begin : g_bad_nch
        $error("NCH must lie between 4 and 8");
    end

    // ------------------------------------------------------------------------
    // Synchronisation of pins and supply levels
    // ------------------------------------------------------------------------
    logic [4:0] pins_s;                              // Synchronised levels
    logic       in_a_s;                              // Input a level
    logic       in_b_s;                              // Input b level
    logic       lp_n_s;                              // Low-power pin level
    logic       buv_s;                               // Battery undervoltage
    logic       luv_s;                               // Logic undervoltage

    // Input, low-power and supply pins pass two flops before use; PWM generator and bus inputs do not
    dpm_sync #(
        .W (5)
    ) u_sync (
        .clk_in    (ref_clk_in),
        .arst_n_in (arst_n_in),
        .async_in  ({logic_uv_in, battery_uv_in, low_power_n_in,
                     direct_input_b_in, direct_input_a_in}),
        .sync_out  (pins_s)
    );

    assign in_a_s = pins_s[0];
    assign in_b_s = pins_s[1];
    assign lp_n_s = pins_s[2];
    assign buv_s  = pins_s[3];
    assign luv_s  = pins_s[4];

    // ------------------------------------------------------------------------
    // Mode and supply decode
    // ------------------------------------------------------------------------
    wire        any_in     = in_a_s | in_b_s;                // Some input high
    wire        sleep_cond = !lp_n_s && !any_in;             // Sleep request
    wire        uv_mon_en  = !sleep_cond;                    // Monitors powered
    wire        buv_eff    = buv_s & uv_mon_en;
    wire        luv_eff    = luv_s & uv_mon_en;
    wire        both_uv    = buv_eff & luv_eff;              // Both supplies low
    wire        soft_rst   = !lp_n_s || luv_eff;             // Register reset
    wire        bus_block  = sleep_cond || luv_eff;          // Bus refused

    dpm_pkg::dpm_mode_t mode_q;                      // Current mode
    dpm_pkg::dpm_mode_t mode_d;                      // Next mode

    // ------------------------------------------------------------------------
    // Registers visible to software
    // ------------------------------------------------------------------------
    logic [NCH-1:0] chan_q;                          // channel_on_bits
    logic [NCH-1:0] map_a_q;                         // input_route_map_a
    logic [NCH-1:0] map_b_q;                         // input_route_map_b
    logic [2:0]     ctrl_q;                          // Activation and PWM enables
    logic [NCH-1:0] pmap_a_q;                        // PWM a routing
    logic [NCH-1:0] pmap_b_q;                        // PWM b routing
    logic [1:0]     lvl_q;                           // input_level_monitor
    logic [NCH-1:0] cmd_q;                           // Registered channel commands

    // Resize an 8-bit constant to the channel width
    function automatic logic [NCH-1:0] fit(input logic [7:0] v);
        logic [7:0] t;
        t = v;
        return t[NCH-1:0];
    endfunction

    // ------------------------------------------------------------------------
    // Avalon slave handshake
    // ------------------------------------------------------------------------
    logic                       ack_q;               // Answer cycle marker
    logic [dpm_pkg::DATA_W-1:0] rdata_q;             // Registered read data
    wire                        req     = avs_read | avs_write;    // Any request
    wire                        wr_take = avs_write & ack_q;       // Write commits
    wire                        wr_ok   = wr_take & !bus_block;    // Write accepted

    // Address decode
    wire sel_chan  = avs_address == dpm_pkg::OFS_CHAN;
    wire sel_map_a = avs_address == dpm_pkg::OFS_MAP_A;
    wire sel_map_b = avs_address == dpm_pkg::OFS_MAP_B;
    wire sel_ctrl  = avs_address == dpm_pkg::OFS_CTRL;
    wire sel_pmapa = avs_address == dpm_pkg::OFS_PMAPA;
    wire sel_pmapb = avs_address == dpm_pkg::OFS_PMAPB;
    wire sel_stat  = avs_address == dpm_pkg::OFS_STAT;

    // One wait state, answer on the second edge
    assign avs_waitrequest = req & !ack_q;

    // Status word
    wire [dpm_pkg::DATA_W-1:0] stat_word = {26'h0, luv_eff, buv_eff, mode_q, lvl_q};

    // Read mux, zero for unmapped or refused
    wire [dpm_pkg::DATA_W-1:0] rd_mux =
        bus_block ? 32'h0 :
        sel_chan  ? {{(32-NCH){1'b0}}, chan_q}   :
        sel_map_a ? {{(32-NCH){1'b0}}, map_a_q}  :
        sel_map_b ? {{(32-NCH){1'b0}}, map_b_q}  :
        sel_ctrl  ? {29'h0, ctrl_q}              :
        sel_pmapa ? {{(32-NCH){1'b0}}, pmap_a_q} :
        sel_pmapb ? {{(32-NCH){1'b0}}, pmap_b_q} :
        sel_stat  ? stat_word                    : 32'h0;

    // Handshake and read data capture
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ack_q   <= 1'b0;
            rdata_q <= 32'h0;
        end else begin
            ack_q <= req & !ack_q;
            if (avs_read && !ack_q) begin
                rdata_q <= rd_mux;
            end
        end
    end

    assign avs_readdata = rdata_q;

    // ------------------------------------------------------------------------
    // Register writes with supply and pin resets
    // ------------------------------------------------------------------------
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            chan_q   <= fit(dpm_pkg::RST_CHAN);
            map_a_q  <= fit(dpm_pkg::RST_MAP_A);
            map_b_q  <= fit(dpm_pkg::RST_MAP_B);
            ctrl_q   <= dpm_pkg::RST_CTRL;
            pmap_a_q <= fit(dpm_pkg::RST_PMAP);
            pmap_b_q <= fit(dpm_pkg::RST_PMAP);
        end else if (soft_rst) begin
            chan_q   <= fit(dpm_pkg::RST_CHAN);
            map_a_q  <= fit(dpm_pkg::RST_MAP_A);
            map_b_q  <= fit(dpm_pkg::RST_MAP_B);
            ctrl_q   <= dpm_pkg::RST_CTRL;
            pmap_a_q <= fit(dpm_pkg::RST_PMAP);
            pmap_b_q <= fit(dpm_pkg::RST_PMAP);
        end else if (wr_ok) begin
            if (sel_chan) begin
                chan_q <= avs_writedata[NCH-1:0];
            end
            if (sel_map_a) begin
                map_a_q <= avs_writedata[NCH-1:0];
            end
            if (sel_map_b) begin
                map_b_q <= avs_writedata[NCH-1:0];
            end
            if (sel_ctrl) begin
                ctrl_q <= avs_writedata[2:0];
            end
            if (sel_pmapa) begin
                pmap_a_q <= avs_writedata[NCH-1:0];
            end
            if (sel_pmapb) begin
                pmap_b_q <= avs_writedata[NCH-1:0];
            end
        end
    end

    // ------------------------------------------------------------------------
    // Level monitor, free of any reset but the power-on one
    // ------------------------------------------------------------------------
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            lvl_q <= 2'h0;
        end else begin
            lvl_q <= {in_b_s, in_a_s};
        end
    end

    // ------------------------------------------------------------------------
    // Mode selection
    // ------------------------------------------------------------------------
    always_comb begin
        if (!lp_n_s && any_in) begin
            mode_d = dpm_pkg::MODE_FAILSAFE;
        end else if (!lp_n_s) begin
            mode_d = dpm_pkg::MODE_SLEEP;
        end else if (ctrl_q[dpm_pkg::CTRL_ACT]) begin
            mode_d = dpm_pkg::MODE_ACTIVE;
        end else begin
            mode_d = dpm_pkg::MODE_IDLE;
        end
    end

    // Mode register
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            mode_q <= dpm_pkg::MODE_SLEEP;
        end else begin
            mode_q <= mode_d;
        end
    end

    assign mode_out          = mode_q;
    assign uv_monitor_en_out = uv_mon_en;
    assign serial_out_en_out = !bus_block & !both_uv;

    // ------------------------------------------------------------------------
    // Channel command combination
    // ------------------------------------------------------------------------
    wire [NCH-1:0] route_a  = in_a_s ? map_a_q : '0;                 // Input a path
    wire [NCH-1:0] route_b  = in_b_s ? map_b_q : '0;                 // Input b path
    wire           pwm_a_on = pwm_gen_a_in & ctrl_q[dpm_pkg::CTRL_PWMA]; // Gen a live
    wire           pwm_b_on = pwm_gen_b_in & ctrl_q[dpm_pkg::CTRL_PWMB]; // Gen b live
    wire [NCH-1:0] route_pa = pwm_a_on ? pmap_a_q : '0;              // PWM a path
    wire [NCH-1:0] route_pb = pwm_b_on ? pmap_b_q : '0;              // PWM b path
    wire [NCH-1:0] or_cmd   = chan_q | route_a | route_b | route_pa | route_pb;
    // Fail-safe drives default channels only
    wire [NCH-1:0] fs_cmd   = (in_a_s ? fit(dpm_pkg::RST_MAP_A) : '0) |
                              (in_b_s ? fit(dpm_pkg::RST_MAP_B) : '0);
    wire [NCH-1:0] cmd_d    = buv_eff              ? '0     :
                              !lp_n_s              ? fs_cmd :
                              or_cmd;

    // Registered commands to the power stages
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cmd_q <= '0;
        end else begin
            cmd_q <= cmd_d;
        end
    end

    assign channel_cmd_out = cmd_q;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!arst_n_in);

    a_default_route: assert property (soft_rst |=>
        map_a_q == fit(dpm_pkg::RST_MAP_A) && map_b_q == fit(dpm_pkg::RST_MAP_B))
        else $error("default routing lost after reset");

    a_map_write: assert property (wr_ok && sel_map_a && !soft_rst |=>
        map_a_q == $past(avs_writedata[NCH-1:0]))
        else $error("route map a write not stored");

    a_or_combine: assert property (lp_n_s && !buv_eff |=>
        channel_cmd_out == $past(or_cmd) && (channel_cmd_out & $past(chan_q)) == $past(chan_q))
        else $error("channel command is not the OR of sources");

    a_level_mon: assert property (##1 lvl_q == {$past(in_b_s), $past(in_a_s)})
        else $error("level monitor does not follow inputs");

    a_failsafe_entry: assert property (!lp_n_s && any_in |=>
        mode_q == dpm_pkg::MODE_FAILSAFE && ($past(buv_eff) || channel_cmd_out == $past(fs_cmd)))
        else $error("fail-safe entry or default channels wrong");

    a_sleep_entry: assert property (sleep_cond |=> mode_q == dpm_pkg::MODE_SLEEP)
        else $error("sleep not entered");

    a_reg_reset: assert property (!lp_n_s |=> chan_q == '0 && ctrl_q == 3'h0)
        else $error("low-power pin did not reset registers");

    a_uv_disable: assert property (sleep_cond |-> !uv_monitor_en_out && !buv_eff)
        else $error("undervoltage monitors active in sleep");

    a_bus_refuse: assert property (bus_block && avs_read && !ack_q |->
        !serial_out_en_out ##1 avs_readdata == 32'h0)
        else $error("bus transfer served while refused");

    a_both_uv_off: assert property (both_uv [*2] |-> channel_cmd_out == '0
        && !serial_out_en_out)
        else $error("channels on under double undervoltage");

    a_batt_recover: assert property (buv_eff ##1 (!buv_eff && lp_n_s) |=>
        channel_cmd_out == $past(or_cmd))
        else $error("channels not restored after battery recovery");

    a_pin_sync: assert property (lp_n_s && !$past(lp_n_s) && $past(arst_n_in, 3) |->
        $past(low_power_n_in, 2) && !$past(low_power_n_in, 3))
        else $error("low-power pin used without synchronisation");

endmodule // dpm_top

// File: verification/dpm_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Host model driving the control pins
// ----------------------------------------------------------------
module dpm_host_model #(
    parameter int MIN_HOLD = 4          // Low-power level hold, cycles
) (
    input  wire logic clk_in,           // Clock
    input  wire logic arst_n_in,        // Async reset, active low
    input  wire logic want_a_in,        // Requested level, input a
    input  wire logic want_b_in,        // Requested level, input b
    input  wire logic want_lp_n_in,     // Requested low-power level
    output logic      pin_a_out,        // Direct input a pin
    output logic      pin_b_out,        // Direct input b pin
    output logic      pin_lp_n_out      // Low-power pin
);
    logic [7:0] hold_q;                 // Cycles since last low-power change

    // Inputs follow on the next edge; low-power waits out its hold time
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pin_a_out    <= 1'b0;
            pin_b_out    <= 1'b0;
            pin_lp_n_out <= 1'b1;
            hold_q       <= 8'h00;
        end else begin
            pin_a_out <= want_a_in;
            pin_b_out <= want_b_in;
            if (want_lp_n_in != pin_lp_n_out && hold_q >= 8'(MIN_HOLD)) begin
                pin_lp_n_out <= want_lp_n_in;
                hold_q       <= 8'h00;
            end else if (hold_q != 8'hFF) begin // Saturate
                hold_q <= hold_q + 8'h01;
            end
        end
    end
endmodule // dpm_host_model

// File: verification/dpm_top_test.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Bench for the pin and supply mode logic
// ----------------------------------------------------------------
module dpm_top_test;
    logic        clk = 1'b0, rst_n = 1'b0;           // Clock, reset
    logic        want_a = 1'b0, want_b = 1'b0;       // Requested inputs
    logic        want_lp_n = 1'b1;                   // Requested low-power
    logic        pin_a, pin_b, pin_lp_n;             // Host-driven pins
    logic        bat_uv = 1'b0, log_uv = 1'b0;       // Supply faults
    logic        pwm_a = 1'b0, pwm_b = 1'b0;         // PWM generators
    logic [4:0]  adr = 5'h00;                        // Bus address
    logic        rd = 1'b0, wr = 1'b0;               // Bus strobes
    logic [31:0] wdat = 32'h0, rbus, rdat;           // Bus data
    logic        wait_rq, uv_en, so_en;              // Stall, enables
    logic [7:0]  ch;                                 // Channel commands
    logic [1:0]  mode;                               // Operating mode
    int          fails = 0, n_checks = 0, cyc = 0;   // Counters

    always #25 clk = ~clk;                           // 20 MHz

    dpm_top u_dpm_top (.ref_clk_in(clk), .arst_n_in(rst_n), .direct_input_a_in(pin_a),
        .direct_input_b_in(pin_b), .low_power_n_in(pin_lp_n), .battery_uv_in(bat_uv),
        .logic_uv_in(log_uv), .pwm_gen_a_in(pwm_a), .pwm_gen_b_in(pwm_b),
        .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wdat),
        .avs_readdata(rbus), .avs_waitrequest(wait_rq), .channel_cmd_out(ch),
        .mode_out(mode), .uv_monitor_en_out(uv_en), .serial_out_en_out(so_en));
    dpm_host_model u_dpm_host_model (.clk_in(clk), .arst_n_in(rst_n), .want_a_in(want_a),
        .want_b_in(want_b), .want_lp_n_in(want_lp_n), .pin_a_out(pin_a),
        .pin_b_out(pin_b), .pin_lp_n_out(pin_lp_n));

    // Verdict and end of run
    task automatic report_and_stop;
        if (fails == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Compare a port value
    task automatic chk_pin(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // One bus transfer, held until the stall drops
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        adr <= a;
        wdat <= d;
        wr <= w;
        rd <= !w;
        do begin
            @(posedge clk);
            n++;
        end while (wait_rq !== 1'b0 && n < 50);
        rdat = rbus;
        wr <= 1'b0;
        rd <= 1'b0;
        if (n >= 50) begin // Hung handshake
            fails++;
            report_and_stop();
        end
    endtask
    // Read a register and compare
    task automatic reg_chk(input logic [4:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        n_checks++;
        if (rdat !== exp) begin
            fails++;
            $display("ERROR register %h expected %h seen %h", a, exp, rdat);
        end
    endtask
    // Request pin levels, wait for host and synchroniser
    task automatic drive(input logic a, input logic b, input logic lp);
        int n;
        n = 0;
        @(posedge clk);
        want_a <= a;
        want_b <= b;
        want_lp_n <= lp;
        do begin
            @(posedge clk);
            n++;
        end while ({pin_a, pin_b, pin_lp_n} !== {a, b, lp} && n < 20);
        if (n >= 20) begin // Pins never settled
            fails++;
        end
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask
    // Set supply faults and let them settle
    task automatic set_uv(input logic b, input logic l);
        @(posedge clk);
        bat_uv <= b;
        log_uv <= l;
        repeat (4) @(posedge clk);
        @(negedge clk);
    endtask
    // Expected status word
    function automatic logic [31:0] stat(input logic [1:0] lv, input dpm_pkg::dpm_mode_t m,
                                         input logic bu);
        stat = {30'h0, lv};
        stat[dpm_pkg::STAT_MODE +: 2] = m;
        stat[dpm_pkg::STAT_BUV] = bu;
    endfunction

    // Cycle ceiling against hangs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            report_and_stop();
        end
    end

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        reg_chk(dpm_pkg::OFS_MAP_A, 32'(dpm_pkg::RST_MAP_A));
        reg_chk(dpm_pkg::OFS_MAP_B, 32'(dpm_pkg::RST_MAP_B));
        reg_chk(dpm_pkg::OFS_CHAN, 32'h0);
        reg_chk(5'h1C, 32'h0);
        reg_chk(dpm_pkg::OFS_STAT, stat(2'b00, dpm_pkg::MODE_IDLE, 1'b0));
        drive(1'b1, 1'b0, 1'b1);
        chk_pin("channels", 8'h04, ch);
        reg_chk(dpm_pkg::OFS_STAT, stat(2'b01, dpm_pkg::MODE_IDLE, 1'b0));
        drive(1'b0, 1'b1, 1'b1);
        chk_pin("channels", 8'h08, ch);
        reg_chk(dpm_pkg::OFS_STAT, stat(2'b10, dpm_pkg::MODE_IDLE, 1'b0));
        bus(1'b1, dpm_pkg::OFS_MAP_A, 32'h81);
        bus(1'b1, dpm_pkg::OFS_MAP_B, 32'h02);
        bus(1'b1, dpm_pkg::OFS_CHAN, 32'h10);
        bus(1'b1, dpm_pkg::OFS_CTRL, 32'h07);
        bus(1'b1, dpm_pkg::OFS_PMAPA, 32'h40);
        bus(1'b1, dpm_pkg::OFS_PMAPB, 32'h20);
        @(posedge clk);
        pwm_a <= 1'b1;
        pwm_b <= 1'b1;
        drive(1'b1, 1'b1, 1'b1);
        chk_pin("channels", 8'hF3, ch);
        chk_pin("mode", 8'(dpm_pkg::MODE_ACTIVE), {6'h00, mode});
        @(posedge clk);
        pwm_a <= 1'b0;
        drive(1'b1, 1'b0, 1'b1);
        chk_pin("channels", 8'hB1, ch);
        @(posedge clk);
        pwm_b <= 1'b0;
        drive(1'b1, 1'b0, 1'b0);
        chk_pin("mode", 8'(dpm_pkg::MODE_FAILSAFE), {6'h00, mode});
        chk_pin("channels", 8'h04, ch);
        reg_chk(dpm_pkg::OFS_STAT, stat(2'b01, dpm_pkg::MODE_FAILSAFE, 1'b0));
        bus(1'b1, dpm_pkg::OFS_CHAN, 32'hFF);
        reg_chk(dpm_pkg::OFS_MAP_A, 32'(dpm_pkg::RST_MAP_A));
        chk_pin("channels", 8'h04, ch);
        drive(1'b0, 1'b1, 1'b0);
        chk_pin("channels", 8'h08, ch);
        drive(1'b0, 1'b0, 1'b0);
        chk_pin("mode", 8'(dpm_pkg::MODE_SLEEP), {6'h00, mode});
        chk_pin("uv monitor", 8'h00, {7'h00, uv_en});
        chk_pin("serial out", 8'h00, {7'h00, so_en});
        reg_chk(dpm_pkg::OFS_MAP_A, 32'h0);
        drive(1'b0, 1'b0, 1'b1);
        chk_pin("uv monitor", 8'h01, {7'h00, uv_en});
        bus(1'b1, dpm_pkg::OFS_CTRL, 32'h01);
        bus(1'b1, dpm_pkg::OFS_CHAN, 32'h55);
        set_uv(1'b1, 1'b0);
        chk_pin("channels", 8'h00, ch);
        reg_chk(dpm_pkg::OFS_STAT, stat(2'b00, dpm_pkg::MODE_ACTIVE, 1'b1));
        set_uv(1'b0, 1'b0);
        chk_pin("channels", 8'h55, ch);
        bus(1'b1, dpm_pkg::OFS_MAP_B, 32'hFF);
        set_uv(1'b0, 1'b1);
        chk_pin("serial out", 8'h00, {7'h00, so_en});
        reg_chk(dpm_pkg::OFS_MAP_B, 32'h0);
        set_uv(1'b0, 1'b0);
        reg_chk(dpm_pkg::OFS_MAP_B, 32'(dpm_pkg::RST_MAP_B));
        reg_chk(dpm_pkg::OFS_CHAN, 32'h0);
        bus(1'b1, dpm_pkg::OFS_CHAN, 32'h33);
        set_uv(1'b1, 1'b1);
        chk_pin("channels", 8'h00, ch);
        chk_pin("serial out", 8'h00, {7'h00, so_en});
        set_uv(1'b0, 1'b0);
        reg_chk(dpm_pkg::OFS_CHAN, 32'h0);
        report_and_stop();
    end
endmodule // dpm_top_test
